// File: rtl/tsrb_defines.svh
`ifndef TSRB_DEFINES_SVH
`define TSRB_DEFINES_SVH
// ==========================================================
// register offsets
`define TSRB_OFS_RC_OSC_TUNE_LOW    6'h28
`define TSRB_OFS_SYNTH_TEST_CTRL    6'h29
`define TSRB_OFS_PRODUCTION_TEST    6'h2a
`define TSRB_OFS_GAIN_CTRL_TEST     6'h2b
`define TSRB_OFS_TEST_SETTINGS_TWO  6'h2c
`define TSRB_OFS_TEST_SETTINGS_ONE  6'h2d
`define TSRB_OFS_TEST_SETTINGS_ZERO 6'h2e
`define TSRB_OFS_PART_ID            6'h30
`define TSRB_OFS_CHIP_REVISION      6'h31
`define TSRB_OFS_FREQ_OFFSET_EST    6'h32
`define TSRB_OFS_LINK_QUALITY       6'h33
// ==========================================================
// reset values
`define TSRB_RST_RC_OSC_TUNE_LOW    7'h00
`define TSRB_RST_SYNTH_TEST_CTRL    8'h59
`define TSRB_RST_PRODUCTION_TEST    8'h7f
`define TSRB_RST_GAIN_CTRL_TEST     8'h3f
`define TSRB_RST_TEST_SETTINGS_TWO  8'h88
`define TSRB_RST_TEST_SETTINGS_ONE  8'h31
`define TSRB_RST_TEST_SETTINGS_ZERO 8'h0b
// ==========================================================
// field positions and special values
`define TSRB_BIT_OSC_SEL_CAL        1
`define TSRB_BIT_CRC_OK             7
`define TSRB_VAL_TEMP_SENSOR_ON     8'hbf
`define TSRB_LQI_SYMBOLS            7'h40
// ==========================================================
// modulation format codes
`define TSRB_MOD_2FSK               3'h0
`define TSRB_MOD_GFSK               3'h1
`define TSRB_MOD_OOK                3'h3
`define TSRB_MOD_MSK                3'h7
`endif

// File: rtl/tsrb_pkg.sv
package tsrb_pkg;
    typedef enum logic {
        TSRB_LQI_IDLE,
        TSRB_LQI_COUNT
    } tsrb_lqi_state_t;

    typedef struct packed {
        logic [1:0]      rst_sync;
        logic [6:0]      rc_osc_tune_low;
        logic [7:0]      synth_test_ctrl;
        logic [7:0]      production_test;
        logic [7:0]      gain_ctrl_test;
        logic [7:0]      test_settings_two;
        logic [7:0]      test_settings_one;
        logic [7:0]      test_settings_zero;
        logic [7:0]      carrier_offset_value;
        logic            crc_ok;
        logic [6:0]      link_quality_value;
        tsrb_lqi_state_t lqi_state;
        logic [6:0]      lqi_count;
        logic [6:0]      lqi_accum;
        logic [7:0]      rdata;
        logic            temp_sensor_en;
    } tsrb_state_t;
endpackage : tsrb_pkg

// File: rtl/tsrb_reg_bank.sv
`timescale 1ns/1ps
`include "tsrb_defines.svh"
// Behaviour
// R1 - seven-bit rc oscillator tune, top bit reserved
// R2 - test registers 0x29..0x2e reset on sleep
// R3 - host leaves factory test registers untouched
// R4 - 0xbf in production test enables sensor in idle
// R5 - host restores 0x7f before leaving idle
// R6 - host may set test two to 0x81
// R7 - host may set test one to 0x35
// R8 - test zero bit 1 enables oscillator selection calibration
// R9 - fixed read-only part and revision codes
// R10 - signed eight-bit carrier offset estimate readable
// R11 - offset estimate reads zero under on-off keying
// R12 - offset compensation only for fsk, gfsk, msk
// R13 - crc match bit set, cleared on receive entry
// R14 - seven-bit link quality over 64 symbols
// R15 - reserved bits read zero, writes ignored
module tsrb_reg_bank
    import tsrb_pkg::*;
#(
    parameter logic [7:0] PART_ID_CODE  = 8'h5a,  // arbitrary value
    parameter logic [7:0] REVISION_CODE = 8'h0e   // arbitrary value
) (
    input  wire logic       REF_CLK_IN,            // 250 MHz clock
    input  wire logic       ARST_N_IN,             // async reset, active low
    input  wire logic [5:0] REG_ADDR_IN,           // register address
    input  wire logic       REG_WR_IN,             // write strobe
    input  wire logic       REG_RD_IN,             // read strobe
    input  wire logic [7:0] REG_WDATA_IN,          // write data
    input  wire logic       SLEEP_ENTER_IN,        // pulse: entering sleep
    input  wire logic       IDLE_STATE_IN,         // level: radio in idle
    input  wire logic [2:0] MOD_FORMAT_IN,         // modulation format code
    input  wire logic       FREQ_EST_VALID_IN,     // pulse: new offset estimate
    input  wire logic [7:0] FREQ_EST_IN,           // offset estimate, signed
    input  wire logic       RX_START_IN,           // pulse: enter or restart rx
    input  wire logic       CRC_DONE_IN,           // pulse: crc compared
    input  wire logic       CRC_MATCH_IN,          // crc compare result
    input  wire logic       SYNC_FOUND_IN,         // pulse: sync word detected
    input  wire logic       SYMBOL_STB_IN,         // pulse: one symbol demodulated
    input  wire logic       SYMBOL_ERR_IN,         // symbol quality miss
    output logic      [7:0] REG_RDATA_OUT,         // read data, one cycle later
    output logic      [6:0] RC_OSC_TUNE_OUT,       // rc oscillator tuning
    output logic            OSC_SEL_CAL_EN_OUT,    // oscillator-selection cal on
    output logic            TEMP_SENSOR_EN_OUT,    // temperature sensor on
    output logic            FREQ_COMP_EN_OUT       // offset compensation allowed
);
    tsrb_state_t s_q;
    tsrb_state_t s_d;
    logic        rst_n;
    logic        freq_supported;
    logic        comp_en_q;

    assign rst_n          = s_q.rst_sync[1];
    assign freq_supported = (MOD_FORMAT_IN == `TSRB_MOD_2FSK) || (MOD_FORMAT_IN == `TSRB_MOD_GFSK)
                          || (MOD_FORMAT_IN == `TSRB_MOD_MSK);  // R12

    // ==========================================================
    // next state
    always_comb begin
        s_d          = s_q;
        s_d.rst_sync = {s_q.rst_sync[0], 1'b1};
        if (REG_WR_IN) begin
            unique case (REG_ADDR_IN)
                `TSRB_OFS_RC_OSC_TUNE_LOW:    s_d.rc_osc_tune_low    = REG_WDATA_IN[6:0];  // R1
                `TSRB_OFS_SYNTH_TEST_CTRL:    s_d.synth_test_ctrl    = REG_WDATA_IN;
                `TSRB_OFS_PRODUCTION_TEST:    s_d.production_test    = REG_WDATA_IN;
                `TSRB_OFS_GAIN_CTRL_TEST:     s_d.gain_ctrl_test     = REG_WDATA_IN;
                `TSRB_OFS_TEST_SETTINGS_TWO:  s_d.test_settings_two  = REG_WDATA_IN;
                `TSRB_OFS_TEST_SETTINGS_ONE:  s_d.test_settings_one  = REG_WDATA_IN;
                `TSRB_OFS_TEST_SETTINGS_ZERO: s_d.test_settings_zero = REG_WDATA_IN;
                default: ;  // R15
            endcase
        end
        // sleep wipes the volatile test block, overriding a same-cycle write
        if (SLEEP_ENTER_IN) begin
            s_d.synth_test_ctrl    = `TSRB_RST_SYNTH_TEST_CTRL;    // R2
            s_d.production_test    = `TSRB_RST_PRODUCTION_TEST;    // R2
            s_d.gain_ctrl_test     = `TSRB_RST_GAIN_CTRL_TEST;     // R2
            s_d.test_settings_two  = `TSRB_RST_TEST_SETTINGS_TWO;  // R2
            s_d.test_settings_one  = `TSRB_RST_TEST_SETTINGS_ONE;  // R2
            s_d.test_settings_zero = `TSRB_RST_TEST_SETTINGS_ZERO; // R2
        end
        if (FREQ_EST_VALID_IN && freq_supported)
            s_d.carrier_offset_value = FREQ_EST_IN;  // R10
        // set wins over clear
        if (RX_START_IN)
            s_d.crc_ok = 1'b0;  // R13
        if (CRC_DONE_IN && CRC_MATCH_IN)
            s_d.crc_ok = 1'b1;  // R13
        else if (CRC_DONE_IN)
            s_d.crc_ok = 1'b0;
        // link quality window
        unique case (s_q.lqi_state)
            TSRB_LQI_IDLE: begin
                if (SYNC_FOUND_IN) begin
                    s_d.lqi_state = TSRB_LQI_COUNT;
                    s_d.lqi_count = 7'h00;
                    s_d.lqi_accum = 7'h00;
                end
            end
            TSRB_LQI_COUNT: begin
                if (SYMBOL_STB_IN) begin
                    s_d.lqi_count = s_q.lqi_count + 7'h01;
                    s_d.lqi_accum = s_q.lqi_accum + {6'h00, SYMBOL_ERR_IN};
                    if (s_q.lqi_count == `TSRB_LQI_SYMBOLS - 7'h01) begin
                        s_d.lqi_state          = TSRB_LQI_IDLE;  // R14
                        s_d.link_quality_value = s_q.lqi_accum + {6'h00, SYMBOL_ERR_IN};  // R14
                    end
                end
            end
        endcase
        s_d.rdata = 8'h00;  // R15
        if (REG_RD_IN) begin
            unique case (REG_ADDR_IN)
                `TSRB_OFS_RC_OSC_TUNE_LOW:    s_d.rdata = {1'b0, s_q.rc_osc_tune_low};  // R1
                `TSRB_OFS_SYNTH_TEST_CTRL:    s_d.rdata = s_q.synth_test_ctrl;
                `TSRB_OFS_PRODUCTION_TEST:    s_d.rdata = s_q.production_test;
                `TSRB_OFS_GAIN_CTRL_TEST:     s_d.rdata = s_q.gain_ctrl_test;
                `TSRB_OFS_TEST_SETTINGS_TWO:  s_d.rdata = s_q.test_settings_two;
                `TSRB_OFS_TEST_SETTINGS_ONE:  s_d.rdata = s_q.test_settings_one;
                `TSRB_OFS_TEST_SETTINGS_ZERO: s_d.rdata = s_q.test_settings_zero;
                `TSRB_OFS_PART_ID:            s_d.rdata = PART_ID_CODE;   // R9
                `TSRB_OFS_CHIP_REVISION:      s_d.rdata = REVISION_CODE;  // R9
                `TSRB_OFS_FREQ_OFFSET_EST:
                    s_d.rdata = (MOD_FORMAT_IN == `TSRB_MOD_OOK) ? 8'h00 : s_q.carrier_offset_value;  // R11
                `TSRB_OFS_LINK_QUALITY:       s_d.rdata = {s_q.crc_ok, s_q.link_quality_value};  // R13
                default:                      s_d.rdata = 8'h00;  // R15
            endcase
        end
        s_d.temp_sensor_en = IDLE_STATE_IN && (s_d.production_test == `TSRB_VAL_TEMP_SENSOR_ON);  // R4
    end

    // ==========================================================
    // state register
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            s_q                    <= '0;
            s_q.rc_osc_tune_low    <= `TSRB_RST_RC_OSC_TUNE_LOW;
            s_q.synth_test_ctrl    <= `TSRB_RST_SYNTH_TEST_CTRL;
            s_q.production_test    <= `TSRB_RST_PRODUCTION_TEST;
            s_q.gain_ctrl_test     <= `TSRB_RST_GAIN_CTRL_TEST;
            s_q.test_settings_two  <= `TSRB_RST_TEST_SETTINGS_TWO;
            s_q.test_settings_one  <= `TSRB_RST_TEST_SETTINGS_ONE;
            s_q.test_settings_zero <= `TSRB_RST_TEST_SETTINGS_ZERO;
            s_q.lqi_state          <= TSRB_LQI_IDLE;
        end else if (!rst_n) begin
            s_q.rst_sync <= s_d.rst_sync;
        end else begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN)
            comp_en_q <= 1'b0;
        else
            comp_en_q <= freq_supported;  // R12
    end

    assign REG_RDATA_OUT      = s_q.rdata;
    assign RC_OSC_TUNE_OUT    = s_q.rc_osc_tune_low;
    assign OSC_SEL_CAL_EN_OUT = s_q.test_settings_zero[`TSRB_BIT_OSC_SEL_CAL];  // R8
    assign TEMP_SENSOR_EN_OUT = s_q.temp_sensor_en;
    assign FREQ_COMP_EN_OUT   = comp_en_q;

    // ==========================================================
    // checks
    property p_rc_tune_write;
        @(posedge REF_CLK_IN) disable iff (!rst_n)
        REG_WR_IN && REG_ADDR_IN == `TSRB_OFS_RC_OSC_TUNE_LOW |=> RC_OSC_TUNE_OUT == $past(REG_WDATA_IN[6:0]);
    endproperty
    a_rc_tune_write: assert property (p_rc_tune_write) else $error("rc tune not written");  // R1
    property p_sleep_wipe;
        @(posedge REF_CLK_IN) disable iff (!rst_n)
        SLEEP_ENTER_IN |=> s_q.production_test == 8'h7f && s_q.test_settings_zero == 8'h0b;
    endproperty
    a_sleep_wipe: assert property (p_sleep_wipe) else $error("test regs kept over sleep");  // R2
    property p_temp_sensor;
        @(posedge REF_CLK_IN) disable iff (!rst_n)
        TEMP_SENSOR_EN_OUT |-> $past(IDLE_STATE_IN) && s_q.production_test == 8'hbf;
    endproperty
    a_temp_sensor: assert property (p_temp_sensor) else $error("sensor on outside idle");  // R4
    property p_osc_cal;
        @(posedge REF_CLK_IN) disable iff (!rst_n)
        REG_WR_IN && REG_ADDR_IN == `TSRB_OFS_TEST_SETTINGS_ZERO && !SLEEP_ENTER_IN
        |=> OSC_SEL_CAL_EN_OUT == $past(REG_WDATA_IN[1]);
    endproperty
    a_osc_cal: assert property (p_osc_cal) else $error("cal enable mismatch");  // R8
    property p_part_id;
        @(posedge REF_CLK_IN) disable iff (!rst_n)
        REG_RD_IN && REG_ADDR_IN == `TSRB_OFS_PART_ID |=> REG_RDATA_OUT == PART_ID_CODE;
    endproperty
    a_part_id: assert property (p_part_id) else $error("part id wrong");  // R9
    property p_ook_zero;
        @(posedge REF_CLK_IN) disable iff (!rst_n)
        REG_RD_IN && REG_ADDR_IN == `TSRB_OFS_FREQ_OFFSET_EST && MOD_FORMAT_IN == `TSRB_MOD_OOK
        |=> REG_RDATA_OUT == 8'h00;
    endproperty
    a_ook_zero: assert property (p_ook_zero) else $error("offset nonzero under ook");  // R11
    property p_offset_hold;
        @(posedge REF_CLK_IN) disable iff (!rst_n)
        FREQ_EST_VALID_IN && !freq_supported |=> $stable(s_q.carrier_offset_value);
    endproperty
    a_offset_hold: assert property (p_offset_hold) else $error("offset taken for bad format");  // R12
    property p_crc_clear;
        @(posedge REF_CLK_IN) disable iff (!rst_n)
        RX_START_IN && !CRC_DONE_IN |=> !s_q.crc_ok;
    endproperty
    a_crc_clear: assert property (p_crc_clear) else $error("crc bit not cleared");  // R13
    property p_crc_set;
        @(posedge REF_CLK_IN) disable iff (!rst_n)
        CRC_DONE_IN && CRC_MATCH_IN |=> s_q.crc_ok;
    endproperty
    a_crc_set: assert property (p_crc_set) else $error("crc bit not set");  // R13
    property p_lqi_bound;
        @(posedge REF_CLK_IN) disable iff (!rst_n)
        s_q.lqi_state == TSRB_LQI_COUNT |-> s_q.lqi_count < 7'h40 && s_q.lqi_accum <= s_q.lqi_count;
    endproperty
    a_lqi_bound: assert property (p_lqi_bound) else $error("lqi window overrun");  // R14
    property p_unmapped;
        @(posedge REF_CLK_IN) disable iff (!rst_n)
        REG_RD_IN && REG_ADDR_IN == 6'h2f |=> REG_RDATA_OUT == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");  // R15
    c_temp_on:  cover property (@(posedge REF_CLK_IN) disable iff (!rst_n) TEMP_SENSOR_EN_OUT);
    c_lqi_done: cover property (@(posedge REF_CLK_IN) disable iff (!rst_n)
                               s_q.lqi_state == TSRB_LQI_COUNT ##1 s_q.lqi_state == TSRB_LQI_IDLE);
    c_crc_ok:   cover property (@(posedge REF_CLK_IN) disable iff (!rst_n) $rose(s_q.crc_ok));
    c_sleep:    cover property (@(posedge REF_CLK_IN) disable iff (!rst_n) SLEEP_ENTER_IN);
endmodule : tsrb_reg_bank

// File: verification/tsrb_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// host side of the register port
module tsrb_host_model (
    input  wire logic       clk_in,    // bank clock
    input  wire logic [7:0] rdata_in,  // read data from bank
    output logic      [5:0] addr_out,  // register address
    output logic            wr_out,    // write strobe
    output logic            rd_out,    // read strobe
    output logic      [7:0] wdata_out  // write data
);
    initial begin
        addr_out  = 6'h15;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
        wdata_out = 8'h5a;
    end
    // factory test registers never written
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        if (a == 6'h29 || a == 6'h2b) return;
        @(posedge clk_in);
        addr_out  <= a;
        wdata_out <= d;
        wr_out    <= 1'b1;
        @(posedge clk_in);
        wr_out    <= 1'b0;
        addr_out  <= ~a;
        wdata_out <= ~d;
    endtask : wr
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out   <= 1'b1;
        @(posedge clk_in);
        rd_out   <= 1'b0;
        addr_out <= ~a;
        #1;
        d = rdata_in;
    endtask : rd
endmodule : tsrb_host_model

// File: verification/test_and_status_register_bank_tb.sv
`timescale 1ns/1ps
module test_and_status_register_bank_tb;
    localparam logic [7:0] PART = 8'h3c;  // arbitrary value
    localparam logic [7:0] REV  = 8'h07;  // arbitrary value
    logic       clk = 1'b0;
    logic       arst_n = 1'b0;
    logic [5:0] addr;
    logic       wr, rd, cal, temp, comp;
    logic [7:0] wdata, rdata, v;
    logic       sleep = 0, idle = 0, fvalid = 0, rxs = 0, crcd = 0, crcm = 0, sync = 0, stb = 0, serr = 0;
    logic [2:0] modf = 3'h0;
    logic [7:0] fest = 8'h00;
    logic [6:0] tune;
    logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    int         fails = 0;
    int         checked = 0;
    always #2 clk = ~clk;
    tsrb_reg_bank #(.PART_ID_CODE(PART), .REVISION_CODE(REV)) dut (
        .REF_CLK_IN(clk), .ARST_N_IN(arst_n), .REG_ADDR_IN(addr), .REG_WR_IN(wr),
        .REG_RD_IN(rd), .REG_WDATA_IN(wdata), .SLEEP_ENTER_IN(sleep), .IDLE_STATE_IN(idle),
        .MOD_FORMAT_IN(modf), .FREQ_EST_VALID_IN(fvalid), .FREQ_EST_IN(fest), .RX_START_IN(rxs),
        .CRC_DONE_IN(crcd), .CRC_MATCH_IN(crcm), .SYNC_FOUND_IN(sync), .SYMBOL_STB_IN(stb),
        .SYMBOL_ERR_IN(serr), .REG_RDATA_OUT(rdata), .RC_OSC_TUNE_OUT(tune),
        .OSC_SEL_CAL_EN_OUT(cal), .TEMP_SENSOR_EN_OUT(temp), .FREQ_COMP_EN_OUT(comp));
    tsrb_host_model host (.clk_in(clk), .rdata_in(rdata), .addr_out(addr), .wr_out(wr),
        .rd_out(rd), .wdata_out(wdata));
    // ==========================================================
    // checking helpers
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rchk(input logic [5:0] a, input logic [7:0] e);
        host.rd(a, v);
        chk($sformatf("reg %h", a), e, v);
    endtask : rchk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic stop_test;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    initial begin
        #20000;
        fails++;
        stop_test();
    end
    // ==========================================================
    // test sequence
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rchk(6'h28, 8'h00);
        rchk(6'h29, 8'h59);
        rchk(6'h2a, 8'h7f);
        rchk(6'h2b, 8'h3f);
        rchk(6'h2c, 8'h88);
        rchk(6'h2d, 8'h31);
        rchk(6'h2e, 8'h0b);
        rchk(6'h30, PART);
        rchk(6'h31, REV);
        chk("cal", 8'h01, {7'h0, cal});
        host.wr(6'h28, 8'hff);
        rchk(6'h28, 8'h7f);
        chk("tune", 8'h7f, {1'b0, tune});
        host.wr(6'h30, 8'h11);
        rchk(6'h30, PART);
        rchk(6'h2f, 8'h00);
        rchk(6'h3f, 8'h00);
        host.wr(6'h2c, 8'h81);
        host.wr(6'h2d, 8'h35);
        host.wr(6'h2e, 8'h09);
        rchk(6'h2c, 8'h81);
        rchk(6'h2d, 8'h35);
        chk("cal", 8'h00, {7'h0, cal});
        @(posedge clk) sleep <= 1'b1;
        @(posedge clk) sleep <= 1'b0;
        rchk(6'h2c, 8'h88);
        rchk(6'h2d, 8'h31);
        rchk(6'h2e, 8'h0b);
        chk("cal", 8'h01, {7'h0, cal});
        host.wr(6'h2a, 8'hbf);
        cyc(2);
        chk("temp", 8'h00, {7'h0, temp});
        @(posedge clk) idle <= 1'b1;
        cyc(2);
        chk("temp", 8'h01, {7'h0, temp});
        host.wr(6'h2a, 8'h7f);
        cyc(2);
        chk("temp", 8'h00, {7'h0, temp});
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            modf   <= codes[i];
            fvalid <= 1'b1;
            fest   <= 8'h80 + 8'(i);
            @(posedge clk) fvalid <= 1'b0;
            cyc(2);
            rchk(6'h32, (codes[i] == 3'h3) ? 8'h00 : 8'h80 + 8'(i));
            chk("comp", {7'h0, codes[i] != 3'h3}, {7'h0, comp});
        end
        // unsupported format: estimate ignored, last value kept
        @(posedge clk);
        modf   <= 3'h2;
        fvalid <= 1'b1;
        fest   <= 8'h55;
        @(posedge clk) fvalid <= 1'b0;
        cyc(2);
        rchk(6'h32, 8'h83);
        chk("comp", 8'h00, {7'h0, comp});
        @(posedge clk) sync <= 1'b1;
        @(posedge clk) sync <= 1'b0;
        for (int i = 0; i < 64; i++) begin
            @(posedge clk);
            stb  <= 1'b1;
            serr <= (i % 8 == 0);
        end
        @(posedge clk);
        stb  <= 1'b0;
        serr <= 1'b0;
        cyc(2);
        rchk(6'h33, 8'h08);
        @(posedge clk);
        crcd <= 1'b1;
        crcm <= 1'b1;
        @(posedge clk) crcd <= 1'b0;
        rchk(6'h33, 8'h88);
        @(posedge clk) rxs <= 1'b1;
        @(posedge clk) rxs <= 1'b0;
        rchk(6'h33, 8'h08);
        // match and rx restart in one cycle: set wins
        @(posedge clk);
        rxs  <= 1'b1;
        crcd <= 1'b1;
        @(posedge clk);
        rxs  <= 1'b0;
        crcd <= 1'b0;
        rchk(6'h33, 8'h88);
        // reset again mid-run
        @(posedge clk) arst_n <= 1'b0;
        cyc(2);
        chk("tune", 8'h00, {1'b0, tune});
        chk("cal", 8'h01, {7'h0, cal});
        @(posedge clk) arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rchk(6'h28, 8'h00);
        rchk(6'h33, 8'h00);
        stop_test();
    end
endmodule : test_and_status_register_bank_tb
